// ==== hw/irq_detect_mode_reg0.sv ====
// Purpose: Detection-mode register 0 and the detection logic it steers
// Assumes: Sources and pins synchronous to ref_clk; APB slave
// Notes:   Pending bits feed the later priority stage

// ------------------------------------------------------------
// Module
// ------------------------------------------------------------
module irq_detect_mode_reg0 #(
    parameter int NUM_PINS = 6
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [15:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire logic [NUM_PINS-1:0] ext_pin_n,
    input  wire logic                pci_power_management_source_n,
    input  wire logic                pci_fault_source_n,
    input  wire logic [2:0]          timer_unit_n,
    input  wire logic                pci_bridge_source_n,
    input  wire logic                write_timeout_source_n,
    input  wire logic                ecc_error_source_n,
    output logic [13:0]              pending_out
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] mode0_reg;
    logic        global_detect_enable_reg;
    logic [13:0] pending_reg;
    logic [13:0] pending_next;
    logic [13:0] level_active;
    logic [13:0] edge_hit;
    logic [13:0] edge_clear;
    logic [NUM_PINS-1:0] pin_prev_reg;
    logic        apb_setup;
    logic        wr_mode0;
    logic        wr_enable;
    logic        wr_edge_clear;
    logic        addr_ok;
    logic [31:0] rd_value;

    assign apb_setup     = psel & ~penable;
    assign wr_mode0      = psel & penable & pready & pwrite
                           & (paddr == irq_detect_pkg::DETECT_MODE0_OFS);
    assign wr_enable     = psel & penable & pready & pwrite
                           & (paddr == irq_detect_pkg::DETECT_ENABLE_OFS);
    assign wr_edge_clear = psel & penable & pready & pwrite
                           & (paddr == irq_detect_pkg::EDGE_CLEAR_OFS);

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    // Reserved bits and the write-only clear register read as zero
    always_comb begin
        addr_ok  = 1'b1;
        rd_value = 32'h0000_0000;
        case (paddr)
            irq_detect_pkg::DETECT_ENABLE_OFS:
                rd_value = {31'h0000_0000, global_detect_enable_reg};
            irq_detect_pkg::DETECT_MODE0_OFS:
                rd_value = mode0_reg;
            irq_detect_pkg::EDGE_CLEAR_OFS:
                rd_value = 32'h0000_0000;
            irq_detect_pkg::PENDING_OFS:
                rd_value = {18'h0_0000, pending_reg};
            default:
                addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------
    // No wait state: ready rises in the first access phase after setup.
    // The answer is latched at the setup edge, so a read returns the
    // value that stood in the setup cycle.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_value;
            pslverr <= ~addr_ok;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Reserved bits 27:24 are masked so they always read zero
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode0_reg <= irq_detect_pkg::MODE0_RESET;
        end else if (wr_mode0) begin
            mode0_reg <= pwdata & irq_detect_pkg::MODE0_WRITE_MASK;
        end
    end

    // Clearing the enable also flushes every pending bit, so software
    // sees a clean slate when detection is started again
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            global_detect_enable_reg <= 1'b0;
        end else if (wr_enable) begin
            global_detect_enable_reg <= pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    // Internal sources know only code 00 (low level) or disable
    logic [1:0] pci_power_mgmt_mode;
    logic [1:0] pci_error_mode;
    logic [1:0] timer2_mode;
    logic [1:0] timer1_mode;
    logic [1:0] timer0_mode;
    logic [1:0] pci_controller_mode;
    logic [1:0] write_timeout_mode;
    logic [1:0] ecc_error_mode;

    assign pci_power_mgmt_mode =
        mode0_reg[irq_detect_pkg::PCI_POWER_MGMT_MODE_LSB +: 2];
    assign pci_error_mode =
        mode0_reg[irq_detect_pkg::PCI_ERROR_MODE_LSB +: 2];
    assign timer2_mode =
        mode0_reg[irq_detect_pkg::TIMER2_MODE_LSB +: 2];
    assign timer1_mode =
        mode0_reg[irq_detect_pkg::TIMER1_MODE_LSB +: 2];
    assign timer0_mode =
        mode0_reg[irq_detect_pkg::TIMER0_MODE_LSB +: 2];
    assign pci_controller_mode =
        mode0_reg[irq_detect_pkg::PCI_CONTROLLER_MODE_LSB +: 2];
    assign write_timeout_mode =
        mode0_reg[irq_detect_pkg::WRITE_TIMEOUT_MODE_LSB +: 2];
    assign ecc_error_mode =
        mode0_reg[irq_detect_pkg::ECC_ERROR_MODE_LSB +: 2];

    // Source enables: a field other than 00 silences its source
    logic pwr_mgmt_on;
    logic pci_err_on;
    logic timer2_on;
    logic timer1_on;
    logic timer0_on;
    logic pci_ctrl_on;
    logic wr_timeout_on;
    logic ecc_on;

    assign pwr_mgmt_on   = (pci_power_mgmt_mode == 2'h0);
    assign pci_err_on    = (pci_error_mode == 2'h0);
    assign timer2_on     = (timer2_mode == 2'h0);
    assign timer1_on     = (timer1_mode == 2'h0);
    assign timer0_on     = (timer0_mode == 2'h0);
    assign pci_ctrl_on   = (pci_controller_mode == 2'h0);
    assign wr_timeout_on = (write_timeout_mode == 2'h0);
    assign ecc_on        = (ecc_error_mode == 2'h0);

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    // Pending index: 0 ecc, 1 write timeout, 2..7 pins 0..5,
    // 8 PCI controller, 9..11 timers 0..2, 12 PCI error, 13 PCI PM
    logic [13:0] internal_req;
    assign internal_req = {
        ~pci_power_management_source_n & pwr_mgmt_on,
        ~pci_fault_source_n & pci_err_on,
        ~timer_unit_n[2] & timer2_on,
        ~timer_unit_n[1] & timer1_on,
        ~timer_unit_n[0] & timer0_on,
        ~pci_bridge_source_n & pci_ctrl_on,
        6'h00,
        ~write_timeout_source_n & wr_timeout_on,
        ~ecc_error_source_n & ecc_on
    };

    // ------------------------------------------------------------
    // Pin detection
    // ------------------------------------------------------------
    // Pins 0..5 sit at bits 5:4 upward in pairs.
    // Edge modes compare the pin with its value one clock earlier;
    // level modes look at the pin as it is now.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            localparam int LSB = irq_detect_pkg::EXT_PIN0_MODE_LSB + 2*gi;
            logic [1:0] pin_mode;
            logic       cur;
            logic       prv;
            logic       lvl;
            logic       edg;
            assign pin_mode = mode0_reg[LSB+1:LSB];
            assign cur = ext_pin_n[gi];
            assign prv = pin_prev_reg[gi];
            always_comb begin
                lvl = 1'b0;
                edg = 1'b0;
                case (pin_mode)
                    2'h0: lvl = ~cur;
                    2'h1: lvl = cur;
                    2'h2: edg = prv & ~cur;
                    2'h3: edg = ~prv & cur;
                    default: lvl = 1'b0;
                endcase
            end
            assign level_active[2+gi] = lvl;
            assign edge_hit[2+gi]     = edg;
        end
    endgenerate

    assign level_active[1:0]  = internal_req[1:0];
    assign level_active[13:8] = internal_req[13:8];
    assign edge_hit[1:0]      = 2'h0;
    assign edge_hit[13:8]     = 6'h00;

    // Previous sample resets high, the idle level of a low-active pin,
    // so release of reset does not look like a rising edge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pin_prev_reg <= '1;
        end else begin
            pin_prev_reg <= ext_pin_n;
        end
    end

    // ------------------------------------------------------------
    // Pending state
    // ------------------------------------------------------------
    // An edge clear names one pending index; out-of-range indices
    // are ignored rather than wrapping onto another source
    always_comb begin
        edge_clear = 14'h0000;
        if (wr_edge_clear && pwdata[irq_detect_pkg::EDGE_CLEAR_ENABLE_BIT] &&
            pwdata[3:0] < 4'(irq_detect_pkg::NUM_SOURCES)) begin
            edge_clear[pwdata[3:0]] = 1'b1;
        end
    end

    always_comb begin
        if (!global_detect_enable_reg) begin
            pending_next = 14'h0000;
        end else begin
            // Level follows source; edge sticks, set beats clear
            pending_next = level_active
                | edge_hit
                | (pending_reg & ~edge_clear & ~level_mask());
        end
    end

    // Bit set for sources whose pending bit follows the level each
    // cycle; edge-mode pins drop out and keep their bit until cleared
    function automatic logic [13:0] level_mask();
        logic [13:0] m;
        m = 14'h3fff;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (mode0_reg[irq_detect_pkg::EXT_PIN0_MODE_LSB + 2*i + 1]) begin
                m[2+i] = 1'b0;
            end
        end
        return m;
    endfunction

    // pending_out mirrors pending_reg so the port comes from a flop
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pending_reg <= 14'h0000;
            pending_out <= 14'h0000;
        end else begin
            pending_reg <= pending_next;
            pending_out <= pending_next;
        end
    end

endmodule // irq_detect_mode_reg0

// ==== hw/irq_detect_pkg.sv ====
// Purpose: Constants for the detection-mode register 0 block
// Assumes: APB, 32-bit data, byte addresses as printed
// Notes:   Offsets, reset values and mode encodings live here
package irq_detect_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] DETECT_ENABLE_OFS = 16'hf600;
    localparam logic [15:0] DETECT_MODE0_OFS  = 16'hf604;
    localparam logic [15:0] EDGE_CLEAR_OFS    = 16'hf660;
    localparam logic [15:0] PENDING_OFS       = 16'hf680;

    // ------------------------------------------------------------
    // Field layout of the mode register
    // ------------------------------------------------------------
    localparam int PCI_POWER_MGMT_MODE_LSB = 30;
    localparam int PCI_ERROR_MODE_LSB      = 28;
    localparam int TIMER2_MODE_LSB         = 22;
    localparam int TIMER1_MODE_LSB         = 20;
    localparam int TIMER0_MODE_LSB         = 18;
    localparam int PCI_CONTROLLER_MODE_LSB = 16;
    localparam int EXT_PIN0_MODE_LSB       = 4;
    localparam int WRITE_TIMEOUT_MODE_LSB  = 2;
    localparam int ECC_ERROR_MODE_LSB      = 0;
    localparam logic [31:0] MODE0_WRITE_MASK = 32'hf0ff_ffff;
    localparam logic [31:0] MODE0_RESET      = 32'h0000_0000;

    // Edge-clear register: enable bit and source index field
    localparam int EDGE_CLEAR_ENABLE_BIT = 16;
    localparam int EDGE_CLEAR_SOURCE_LSB = 0;

    // Pending bit and external pin counts
    localparam int NUM_SOURCES   = 14;
    localparam int NUM_EXT_PINS  = 6;

    // ------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_LOW     = 2'h0,
        MODE_HIGH    = 2'h1,
        MODE_FALLING = 2'h2,
        MODE_RISING  = 2'h3
    } detect_mode_t;

endpackage

// ==== dv/irq_detect_checker_assertions.sv ====
// Purpose: Port checker for the detection-mode register block
// Assumes: Sources are active low; pending follows one edge later
// Notes:   Attached by bind to every instance of the block
module irq_detect_checker (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pci_power_management_source_n,
    input wire logic        pci_fault_source_n,
    input wire logic [2:0]  timer_unit_n,
    input wire logic        pci_bridge_source_n,
    input wire logic        write_timeout_source_n,
    input wire logic        ecc_error_source_n,
    input wire logic [13:0] pending_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    power_level_a: assert property (pending_out[13] |->
        !$past(pci_power_management_source_n)) else $error("power pend");
    fault_level_a: assert property (pending_out[12] |->
        !$past(pci_fault_source_n)) else $error("fault pend");
    timer2_level_a: assert property (pending_out[11] |->
        !$past(timer_unit_n[2])) else $error("timer2 pend");
    timer1_level_a: assert property (pending_out[10] |->
        !$past(timer_unit_n[1])) else $error("timer1 pend");
    timer0_level_a: assert property (pending_out[9] |->
        !$past(timer_unit_n[0])) else $error("timer0 pend");
    bridge_level_a: assert property (pending_out[8] |->
        !$past(pci_bridge_source_n)) else $error("bridge pend");
    wtimeout_level_a: assert property (pending_out[1] |->
        !$past(write_timeout_source_n)) else $error("timeout pend");
    ecc_level_a: assert property (pending_out[0] |->
        !$past(ecc_error_source_n)) else $error("ecc pend");
    reset_clear_a: assert property ($rose(resetn) |->
        pending_out == 14'h0 && !pready) else $error("not cleared");
    setup_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one access cycle");
    error_with_ready_a: assert property (pslverr |-> pready && penable)
        else $error("pslverr without pready");
endmodule // irq_detect_checker

bind irq_detect_mode_reg0 irq_detect_checker chk (.ref_clk, .resetn, .psel,
    .penable, .pready, .pslverr, .pci_power_management_source_n,
    .pci_fault_source_n, .timer_unit_n, .pci_bridge_source_n,
    .write_timeout_source_n, .ecc_error_source_n, .pending_out);

// ==== dv/irq_source_model.sv ====
// Purpose: Peripheral sources and external pins beside the block
// Assumes: Requests change just after a clock edge
// Notes:   src_n order: power, fault, timers 2..0, bridge, timeout, ecc
module irq_source_model (
    input  wire logic       ref_clk,
    input  wire logic       assert_int,
    input  wire logic [5:0] pin_lvl,
    output logic      [5:0] pin_out,
    output logic      [7:0] src_n
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk) begin
        src_n   <= {8{!assert_int}};
        pin_out <= pin_lvl;
    end
endmodule // irq_source_model

// ==== dv/tb_irq_detect_mode_reg0.sv ====
// Purpose: Self-checking bench for the detection-mode register block
// Assumes: APB answers in the first access cycle
// Notes:   Internal sources held asserted except for one deasserted settle near the end
module tb_irq_detect_mode_reg0;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        asrt, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  pins, pin_w;
    logic [7:0]  src_n;
    logic [13:0] pending_out;
    int          miscompares, checks_done, cyc;

    irq_detect_mode_reg0 dut (.ref_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .ext_pin_n(pin_w),
        .pci_power_management_source_n(src_n[7]),
        .pci_fault_source_n(src_n[6]), .timer_unit_n(src_n[5:3]),
        .pci_bridge_source_n(src_n[2]), .write_timeout_source_n(src_n[1]),
        .ecc_error_source_n(src_n[0]), .pending_out);
    irq_source_model far (.ref_clk, .assert_int(asrt), .pin_lvl(pins),
        .pin_out(pin_w), .src_n);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic settle();
        repeat (4) @(posedge ref_clk);
    endtask

    initial begin
        {psel, penable, pwrite, resetn, paddr, pwdata} = '0;
        asrt = 1'b1;
        pins = 6'h00;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, irq_detect_pkg::DETECT_MODE0_OFS, 32'h0);
        check(rd, irq_detect_pkg::MODE0_RESET);
        apb(1'b1, irq_detect_pkg::DETECT_MODE0_OFS, 32'hffff_ffff);
        apb(1'b0, irq_detect_pkg::DETECT_MODE0_OFS, 32'h0);
        check(rd, irq_detect_pkg::MODE0_WRITE_MASK);
        apb(1'b0, 16'hf700, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, irq_detect_pkg::DETECT_ENABLE_OFS, 32'h1);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, irq_detect_pkg::DETECT_MODE0_OFS, 32'(c) * 32'h5055_0005);
            settle();
            check({18'h0, pending_out}, c != 0 ? 32'h00fc : 32'h3fff);
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, irq_detect_pkg::DETECT_MODE0_OFS, 32'(m) * 32'h0000_5550);
            pins <= 6'h3f;
            settle();
            pins <= 6'h00;
            settle();
            pins <= 6'h3f;
            settle();
            check({18'h0, pending_out}, m != 0 ? 32'h3fff : 32'h3f03);
            for (int i = 2; i < 8; i++)
                apb(1'b1, irq_detect_pkg::EDGE_CLEAR_OFS, 32'h0001_0000 | 32'(i));
            check({18'h0, pending_out}, m == 1 ? 32'h3fff : 32'h3f03);
        end
        apb(1'b0, irq_detect_pkg::PENDING_OFS, 32'h0);
        check(rd, 32'h0000_3f03);
        apb(1'b1, irq_detect_pkg::DETECT_MODE0_OFS, 32'h0);
        asrt <= 1'b0;
        settle();
        check({18'h0, pending_out}, 32'h0);
        asrt <= 1'b1;
        apb(1'b1, irq_detect_pkg::DETECT_ENABLE_OFS, 32'h0);
        settle();
        check({18'h0, pending_out}, 32'h0);
        summarize();
    end
endmodule // tb_irq_detect_mode_reg0
